// >>> bcrs_defines.vh
// Functional notes
// - Bus runs at one quarter of crystal or PLL source clock.
// - Power-on or low voltage: clocks stopped, pin low, for 4096 crystal cycles.
// - Stop exit: counter runs on crystal clock; clocks off until delay expires.
// - Wait mode stops processor clocks; peripheral clocks keep running.
// - Every reset asserts internal reset; vector normal or monitor pair.
// - Internal reset returns registers and modules to defaults.
// - Internal reset clears recovery counter; external pin reset leaves it.
// - Each reset source sets its own flag in the cause register.
// - Pin held low at least 67 cycles sets pin flag unless long reset.
// - Internal source: pin low 32 cycles, internal reset 32 more, then vector.
// - Long reset: pin low 4096 plus 32 cycles, internal reset 32 more.
// - Recovery totals 4163 cycles for long resets and 67 for others.
// - Power-on sets power-on flag and clears all other cause flags.
// - Watchdog overflow generates internal reset and sets watchdog flag.
// - Watchdog disabled only by the two-flop synchronised test voltage in monitor or break.
// - Illegal instruction sets bad opcode flag and resets.
// - Stop with stop enable clear is an illegal opcode reset.
// - Opcode fetch from unmapped address resets; data fetch does not.
// - Low voltage sets its flag and runs the long reset sequence.
// - Monitor entry with erased vectors causes internal reset driving pin.
// - Recovery counter is 12 bits and prescales the watchdog.
// - Stop clears counter; wakeup waits 32 if short bit set, else 4096.
// - Recovery counter runs freely after all reset states end.
// - Clock generator output is source divided by two.
`ifndef BCRS_DEFINES_VH
`define BCRS_DEFINES_VH

`define BCRS_ADDR_CTRL      8'h00
`define BCRS_ADDR_CAUSE     8'h04
`define BCRS_ADDR_STATUS    8'h08

`define BCRS_CTRL_PLL       0
`define BCRS_CTRL_STOPEN    1
`define BCRS_CTRL_SHORTREC  2
`define BCRS_CTRL_OSCSTOP   3
`define BCRS_CTRL_RESET     4'h0

`define BCRS_CAUSE_POR      7
`define BCRS_CAUSE_PIN      6
`define BCRS_CAUSE_WDOG     5
`define BCRS_CAUSE_BADOP    4
`define BCRS_CAUSE_BADADR   3
`define BCRS_CAUSE_MONRST   2
`define BCRS_CAUSE_LOWV     1
`define BCRS_CAUSE_RESET    8'h80

`define BCRS_VEC_NORMAL     16'hFFFE
`define BCRS_VEC_MONITOR    16'hFEFE
`define BCRS_VEC_ERASED     8'hFF

`define BCRS_POR_CYCLES     4096
`define BCRS_STOP_LONG      4096
`define BCRS_STOP_SHORT     32
`define BCRS_PIN_DRIVE      32
`define BCRS_INTERNAL_RESET_EXTRA     32
`define BCRS_VEC_CYCLES     3
`define BCRS_PIN_MIN_LOW    67

`endif

// >>> bcrs_sequencer.v
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bcrs_defines.vh"
module bcrs_sequencer #(
  parameter POR_CYCLES  = `BCRS_POR_CYCLES,
  parameter STOP_LONG   = `BCRS_STOP_LONG,
  parameter STOP_SHORT  = `BCRS_STOP_SHORT,
  parameter PIN_DRIVE   = `BCRS_PIN_DRIVE,
  parameter INTERNAL_RESET_EXTRA  = `BCRS_INTERNAL_RESET_EXTRA,
  parameter VEC_CYCLES  = `BCRS_VEC_CYCLES,
  parameter PIN_MIN_LOW = `BCRS_PIN_MIN_LOW
) (
  // Clock, reset and clock enable.
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        ce,
  // Register bus.
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Reset pin and test voltage sense.
  input  wire        rstPinIn,
  output wire        rstPinOut,
  output reg         rstPinOe,
  input  wire        testHighVoltRst,
  input  wire        testHighVoltIrq,
  // Reset sources.
  input  wire        powerOnPulse,
  input  wire        lowVoltage,
  input  wire        watchdogOverflow,
  input  wire        cpuIllegalOpcode,
  input  wire        cpuOpcodeFetch,
  input  wire        addrUnmapped,
  input  wire        monitorEntry,
  input  wire [7:0]  resetVecHi,
  input  wire [7:0]  resetVecLo,
  // Processor mode inputs.
  input  wire        monitorMode,
  input  wire        breakActive,
  input  wire        cpuStopExec,
  input  wire        cpuWaitExec,
  input  wire        wakeEvent,
  input  wire        pllVcoTick,
  // Clock and reset outputs.
  output reg         clockGenOut,
  output reg         cpuClkEn,
  output reg         periphClkEn,
  output reg         internalReset,
  output reg         resetVecFetch,
  output reg  [15:0] resetVector,
  output reg  [11:0] watchdogPrescale,
  output wire        watchdogDisable,
  output wire        oscOnInStop
);

  localparam [2:0] ST_RUN  = 3'd0;
  localparam [2:0] ST_POR  = 3'd1;
  localparam [2:0] ST_PINL = 3'd2;
  localparam [2:0] ST_INTERNAL_RESET = 3'd3;
  localparam [2:0] ST_VEC  = 3'd4;
  localparam [2:0] ST_EXT  = 3'd5;
  localparam [2:0] ST_STOP = 3'd6;
  localparam [2:0] ST_SREC = 3'd7;

  localparam [31:0] POR_M1     = POR_CYCLES - 1;
  localparam [31:0] LONG_M1    = STOP_LONG - 1;
  localparam [31:0] SHORT_M1   = STOP_SHORT - 1;
  localparam [31:0] DRIVE_M1   = PIN_DRIVE - 1;
  localparam [31:0] INTERNAL_RESET_M1    = INTERNAL_RESET_EXTRA - 1;
  localparam [31:0] VEC_M1     = VEC_CYCLES - 1;
  localparam [31:0] PIN_M1     = PIN_MIN_LOW - 1;
  localparam [11:0] POR_LAST   = POR_M1[11:0];
  localparam [11:0] LONG_LAST  = LONG_M1[11:0];
  localparam [11:0] SHORT_LAST = SHORT_M1[11:0];
  localparam [5:0]  DRIVE_LAST = DRIVE_M1[5:0];
  localparam [5:0]  INTERNAL_RESET_LAST  = INTERNAL_RESET_M1[5:0];
  localparam [5:0]  VEC_LAST   = VEC_M1[5:0];
  localparam [6:0]  PIN_LAST   = PIN_M1[6:0];

  function [7:0] causeBit;
    input integer pos;
    begin
      causeBit = 8'h01 << pos;
    end
  endfunction

  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [11:0] recCnt;
  reg  [5:0]  phCnt;
  reg  [6:0]  pinLowCnt;
  reg  [7:0]  cause;
  reg  [7:0]  next_cause;
  reg  [3:0]  ctrl;
  reg         waitMode;
  reg  [1:0]  divCnt;
  reg         clrRec;
  reg         clrPh;
  reg  [1:0]  pinSync;
  reg  [1:0]  tstRstSync;
  reg  [1:0]  tstIrqSync;

  // Pin and test voltage inputs pass two flip-flops first.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinSync    <= 2'b11;
      tstRstSync <= 2'b00;
      tstIrqSync <= 2'b00;
    end else if (ce) begin
      pinSync    <= {pinSync[0], rstPinIn};
      tstRstSync <= {tstRstSync[0], testHighVoltRst};
      tstIrqSync <= {tstIrqSync[0], testHighVoltIrq};
    end
  end

  wire pinLow      = ~pinSync[1];
  wire pllSelect   = ctrl[`BCRS_CTRL_PLL];
  wire stopEnable  = ctrl[`BCRS_CTRL_STOPEN];
  wire shortRec    = ctrl[`BCRS_CTRL_SHORTREC];
  assign oscOnInStop = ctrl[`BCRS_CTRL_OSCSTOP];
  assign rstPinOut   = 1'b0;

  // Watchdog disable is combinational on the two-flop synchronised test voltage.
  assign watchdogDisable = (monitorMode & (tstRstSync[1] | tstIrqSync[1]))
                         | (breakActive & tstRstSync[1]);

  wire porEv  = powerOnPulse;
  wire lvEv   = lowVoltage;
  wire wdEv   = watchdogOverflow & ~watchdogDisable;
  wire opEv   = cpuIllegalOpcode | (cpuStopExec & ~stopEnable);
  wire adEv   = cpuOpcodeFetch & addrUnmapped;
  wire monEv  = monitorEntry & (resetVecHi == `BCRS_VEC_ERASED)
              & (resetVecLo == `BCRS_VEC_ERASED);
  wire longEv = porEv | lvEv;
  wire accept = (state == ST_RUN) | (state == ST_STOP) | (state == ST_SREC);
  wire shortEv = accept & (wdEv | opEv | adEv | monEv);
  wire pinEv  = accept & pinLow & (pinLowCnt == PIN_LAST);
  wire [11:0] stopLast = shortRec ? SHORT_LAST : LONG_LAST;

  always @* begin
    next_state = state;
    clrRec = 1'b0;
    clrPh  = 1'b0;
    if (longEv) begin
      next_state = ST_POR;
      clrRec = 1'b1;
    end else if (shortEv) begin
      next_state = ST_PINL;
      clrRec = 1'b1;
      clrPh  = 1'b1;
    end else if (pinEv) begin
      next_state = ST_EXT;
    end else begin
      case (state)
        ST_RUN: begin
          if (cpuStopExec & stopEnable) begin
            next_state = ST_STOP;
            clrRec = 1'b1;
          end
        end
        ST_STOP: begin
          if (wakeEvent) begin
            next_state = ST_SREC;
          end
        end
        ST_SREC: begin
          if (recCnt == stopLast) begin
            next_state = ST_RUN;
          end
        end
        ST_POR: begin
          if (recCnt == POR_LAST) begin
            next_state = ST_PINL;
            clrPh = 1'b1;
          end
        end
        ST_PINL: begin
          if (phCnt == DRIVE_LAST) begin
            next_state = ST_INTERNAL_RESET;
            clrPh = 1'b1;
          end
        end
        ST_INTERNAL_RESET: begin
          if (phCnt == INTERNAL_RESET_LAST) begin
            next_state = ST_VEC;
            clrPh = 1'b1;
          end
        end
        ST_VEC: begin
          if (phCnt == VEC_LAST) begin
            next_state = ST_RUN;
          end
        end
        ST_EXT: begin
          if (!pinLow) begin
            next_state = ST_INTERNAL_RESET;
            clrPh = 1'b1;
          end
        end
        default: begin
          next_state = ST_POR;
          clrRec = 1'b1;
        end
      endcase
    end
  end

  // The newest accepted reset replaces the previous cause.
  always @* begin
    next_cause = cause;
    if (porEv) begin
      next_cause = causeBit(`BCRS_CAUSE_POR);
    end else if (lvEv | shortEv | pinEv) begin
      next_cause = 8'h00;
      if (lvEv) begin
        next_cause = causeBit(`BCRS_CAUSE_LOWV);
      end else begin
        if (wdEv) next_cause = next_cause | causeBit(`BCRS_CAUSE_WDOG);
        if (opEv) next_cause = next_cause | causeBit(`BCRS_CAUSE_BADOP);
        if (adEv) next_cause = next_cause | causeBit(`BCRS_CAUSE_BADADR);
        if (monEv) next_cause = next_cause | causeBit(`BCRS_CAUSE_MONRST);
        if (!shortEv) next_cause = causeBit(`BCRS_CAUSE_PIN);
      end
    end
  end

  wire inRst = (next_state == ST_POR) | (next_state == ST_PINL)
             | (next_state == ST_INTERNAL_RESET) | (next_state == ST_EXT);
  wire clocksOn = (next_state != ST_POR) & (next_state != ST_STOP)
                & (next_state != ST_SREC);
  wire srcTick = pllSelect ? pllVcoTick : 1'b1;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state            <= ST_POR;
      recCnt           <= 12'h000;
      phCnt            <= 6'h00;
      pinLowCnt        <= 7'h00;
      cause            <= `BCRS_CAUSE_RESET;
      waitMode         <= 1'b0;
      divCnt           <= 2'b00;
      clockGenOut      <= 1'b0;
      cpuClkEn         <= 1'b0;
      periphClkEn      <= 1'b0;
      internalReset    <= 1'b1;
      rstPinOe         <= 1'b1;
      resetVecFetch    <= 1'b0;
      resetVector      <= `BCRS_VEC_NORMAL;
      watchdogPrescale <= 12'h000;
    end else if (ce) begin
      state <= next_state;
      cause <= next_cause;
      if (clrRec) begin
        recCnt <= 12'h000;
      end else if (state != ST_STOP) begin
        recCnt <= recCnt + 12'h001;
      end
      watchdogPrescale <= recCnt;
      phCnt <= clrPh ? 6'h00 : phCnt + 6'h01;
      if (!pinLow | rstPinOe) begin
        pinLowCnt <= 7'h00;
      end else if (pinLowCnt != PIN_LAST) begin
        pinLowCnt <= pinLowCnt + 7'h01;
      end
      if (inRst | wakeEvent) begin
        waitMode <= 1'b0;
      end else if (cpuWaitExec & (state == ST_RUN)) begin
        waitMode <= 1'b1;
      end
      if (srcTick) begin
        divCnt      <= divCnt + 2'b01;
        clockGenOut <= ~divCnt[0];
      end
      cpuClkEn    <= srcTick & (divCnt == 2'b11) & clocksOn
                   & ~inRst & ~waitMode;
      periphClkEn <= srcTick & (divCnt == 2'b11) & clocksOn;
      internalReset <= inRst;
      rstPinOe      <= (next_state == ST_POR) | (next_state == ST_PINL);
      resetVecFetch <= (next_state == ST_VEC);
      resetVector   <= monitorMode ? `BCRS_VEC_MONITOR : `BCRS_VEC_NORMAL;
    end
  end

  // Register bus slave.
  reg        awHeld;
  reg        wHeld;
  reg [7:0]  awAddrQ;
  reg [31:0] wDataQ;
  reg [3:0]  wStrbQ;
  reg [31:0] rdMux;
  reg        rdHit;

  assign s_axi_awready = ce & ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ce & ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ce & ~s_axi_rvalid;

  wire wrGo = awHeld & wHeld & ~s_axi_bvalid;

  always @* begin
    rdHit = 1'b1;
    case (s_axi_araddr)
      `BCRS_ADDR_CTRL:   rdMux = {28'h000_0000, ctrl};
      `BCRS_ADDR_CAUSE:  rdMux = {24'h00_0000, cause};
      `BCRS_ADDR_STATUS: rdMux = {15'h0000, internalReset, waitMode,
                                  state, recCnt};
      default: begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b0;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddrQ      <= 8'h00;
      wDataQ       <= 32'h0000_0000;
      wStrbQ       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= 2'b00;
      s_axi_rdata  <= 32'h0000_0000;
      ctrl         <= `BCRS_CTRL_RESET;
    end else if (ce) begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld  <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld  <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end
      if (wrGo) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        if ((awAddrQ != `BCRS_ADDR_CTRL) & (awAddrQ != `BCRS_ADDR_CAUSE)
            & (awAddrQ != `BCRS_ADDR_STATUS)) begin
          s_axi_bresp <= 2'b10;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (inRst) begin
        ctrl <= `BCRS_CTRL_RESET;
      end else if (wrGo & (awAddrQ == `BCRS_ADDR_CTRL) & wStrbQ[0]) begin
        ctrl <= wDataQ[3:0];
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> bcrs_seq_props_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcrs_defines.vh"
module bcrs_seq_props #(
  parameter int POR_CYCLES = `BCRS_POR_CYCLES,
  parameter int PIN_DRIVE  = `BCRS_PIN_DRIVE
) (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus handshakes.
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // Reset sources and test sense.
  input wire logic        watchdogOverflow,
  input wire logic        cpuIllegalOpcode,
  input wire logic        cpuOpcodeFetch,
  input wire logic        addrUnmapped,
  input wire logic        testHighVoltRst,
  input wire logic        testHighVoltIrq,
  input wire logic        monitorMode,
  input wire logic        breakActive,
  // Sequencer outputs.
  input wire logic        rstPinOe,
  input wire logic        internalReset,
  input wire logic        resetVecFetch,
  input wire logic [15:0] resetVector,
  input wire logic        cpuClkEn,
  input wire logic        watchdogDisable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [12:0] oeCnt;
  wire quiet = !internalReset && !rstPinOe && !resetVecFetch;
  wire badOp = cpuIllegalOpcode || (cpuOpcodeFetch && addrUnmapped);

  // Counts how long the device has been pulling the pin low.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) oeCnt <= 13'h0000;
    else if (rstPinOe) oeCnt <= oeCnt + 13'h0001;
    else oeCnt <= 13'h0000;
  end

  a_pin_len: assert property ($fell(rstPinOe) |->
    oeCnt == PIN_DRIVE || (oeCnt >= POR_CYCLES + PIN_DRIVE &&
    oeCnt <= POR_CYCLES + PIN_DRIVE + 1))
    else $error("pin drive length wrong");
  a_internal_reset_tail: assert property ($fell(rstPinOe) |-> internalReset
    ##31 (internalReset && !resetVecFetch) ##1 resetVecFetch)
    else $error("internal reset tail wrong");
  a_vec_len: assert property ($rose(resetVecFetch) |->
    resetVecFetch[*3] ##1 !resetVecFetch)
    else $error("vector fetch length wrong");
  a_vec_value: assert property (resetVecFetch |-> resetVector ==
    (monitorMode ? `BCRS_VEC_MONITOR : `BCRS_VEC_NORMAL))
    else $error("reset vector wrong");
  a_short_src: assert property (quiet && (badOp ||
    (watchdogOverflow && !watchdogDisable))
    |=> rstPinOe && internalReset)
    else $error("reset source not answered");
  a_data_fetch: assert property (quiet && addrUnmapped &&
    !cpuOpcodeFetch && !watchdogOverflow && !cpuIllegalOpcode |=> !rstPinOe)
    else $error("data fetch caused reset");
  a_wdog_off: assert property (watchdogDisable |->
    (monitorMode &&
    ($past(testHighVoltRst, 2) || $past(testHighVoltIrq, 2))) ||
    (breakActive && $past(testHighVoltRst, 2)))
    else $error("watchdog disabled without test voltage");
  a_bus_quarter: assert property (cpuClkEn |=> !cpuClkEn[*3])
    else $error("bus clock faster than a quarter");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid)
    else $error("write response dropped early");
endmodule

bind bcrs_sequencer bcrs_seq_props #(.POR_CYCLES(POR_CYCLES),
  .PIN_DRIVE(PIN_DRIVE)) u_props (.clk, .sys_rst, .s_axi_bvalid,
  .s_axi_bready, .watchdogOverflow, .cpuIllegalOpcode, .cpuOpcodeFetch,
  .addrUnmapped, .testHighVoltRst, .testHighVoltIrq, .monitorMode,
  .breakActive, .rstPinOe, .internalReset, .resetVecFetch, .resetVector,
  .cpuClkEn, .watchdogDisable);
`default_nettype wire

// >>> bcrs_pin_party.sv
`timescale 1ns/1ps
`default_nettype none
module bcrs_pin_party (
  // Clock and device side of the pin.
  input  wire logic       clk,
  input  wire logic       devOe,
  input  wire logic       devOut,
  // Command to hold the pin low.
  input  wire logic       press,
  input  wire logic [7:0] pressLen,
  // Resolved pin level.
  output wire logic       pinLevel
);
  logic [7:0] left = 8'h00;

  // Holds the pin low for the commanded number of cycles.
  always @(posedge clk) begin
    if (press) left <= pressLen;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  // The pull-up wins when nobody pulls the pin down.
  assign pinLevel = (devOe ? devOut : 1'b1) & (left == 8'h00);
endmodule
`default_nettype wire

// >>> bcrs_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "bcrs_defines.vh"
module bcrs_sequencer_test;
  localparam int POR = 96;
  logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, testHighVoltRst, testHighVoltIrq;
  logic monitorMode, press, breakActive, pllVcoTick;
  logic [7:0] addr, vecB;
  logic [9:0] srcv;
  logic [31:0] s_axi_wdata, got;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, rstPinOut, rstPinOe, pin, cpuClkEn, periphClkEn;
  wire internalReset, resetVecFetch, watchdogDisable;
  wire clockGenOut, oscOnInStop;
  wire [11:0] watchdogPrescale;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] resetVector;
  logic [9:0] srcTab [6] = '{10'h001, 10'h002, 10'h00C, 10'h010,
                             10'h020, 10'h040};
  logic [7:0] causeTab [6] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h80};
  int fail_count = 0;
  int n_tests = 0;

  bcrs_sequencer #(.POR_CYCLES(POR), .STOP_LONG(POR)) dut_u (.clk,
    .sys_rst, .ce(1'b1), .s_axi_awaddr(addr), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr(addr), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rstPinIn(pin),
    .rstPinOut, .rstPinOe, .testHighVoltRst, .testHighVoltIrq,
    .powerOnPulse(srcv[6]), .lowVoltage(srcv[5]),
    .watchdogOverflow(srcv[0]), .cpuIllegalOpcode(srcv[1]),
    .cpuOpcodeFetch(srcv[2]), .addrUnmapped(srcv[3]),
    .monitorEntry(srcv[4]), .resetVecHi(vecB), .resetVecLo(vecB),
    .monitorMode, .breakActive, .cpuStopExec(srcv[7]),
    .cpuWaitExec(srcv[8]), .wakeEvent(srcv[9]), .pllVcoTick,
    .clockGenOut, .cpuClkEn, .periphClkEn, .internalReset,
    .resetVecFetch, .resetVector, .watchdogPrescale, .watchdogDisable,
    .oscOnInStop);
  bcrs_pin_party party_u (.clk, .devOe(rstPinOe), .devOut(rstPinOut),
    .press, .pressLen(8'h50), .pinLevel(pin));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] e,
                      input logic [1:0] er, input logic [31:0] msk);
    logic ta, tw, tr, done;
    logic [1:0] r;
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(negedge clk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tr = s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      got = s_axi_rdata;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
      n++;
    end while (!done && n < 100);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    chk(done, 1'b1);
    chk(r, er);
    if (!wr) chk(got & msk, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    srcv <= v;
    @(posedge clk);
    srcv <= 10'h000;
  endtask
  task automatic meas(input int expN, input logic [15:0] expV);
    int n, m, v;
    n = 0;
    m = 0;
    v = 0;
    #1;
    while (!rstPinOe && m < 300) begin cyc(1); m++; end
    m = 0;
    while (rstPinOe && n < 9000) begin cyc(1); n++; end
    while (!resetVecFetch && m < 300) begin cyc(1); m++; end
    chk(resetVector, expV);
    while (resetVecFetch && v < 9) begin cyc(1); v++; end
    if (expN != 0) chk(n, expN);
    chk(m, 32);
    chk(v, 3);
  endtask
  task automatic cnt16(output int a, output int b, output int c);
    logic last;
    a = 0;
    b = 0;
    c = 0;
    last = clockGenOut;
    repeat (16) begin
      cyc(1);
      a += cpuClkEn;
      b += periphClkEn;
      c += (clockGenOut != last);
      last = clockGenOut;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The phase-locked source ticks on every second crystal edge.
  always @(posedge clk) pllVcoTick <= !pllVcoTick;
  initial begin
    #3_000_000;
    fail_count++;
    close_out;
  end
  initial begin
    int a, b, c;
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, testHighVoltRst, testHighVoltIrq} = 4'h0;
    {monitorMode, press, breakActive, pllVcoTick, addr, vecB, srcv} = '0;
    vecB = 8'hFF;
    s_axi_wdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    meas(0, `BCRS_VEC_NORMAL);
    xfer(0, 8'h04, 0, 32'h0000_0080, 2'b00, 32'hFFFF_FFFF);
    xfer(0, 8'h40, 0, 32'h0000_0000, 2'b10, 32'hFFFF_FFFF);
    $display("end of power-on test");
    for (int k = 0; k < 6; k++) begin
      xfer(1, 8'h00, 32'h0000_0002, 0, 2'b00, 0);
      monitorMode <= (k == 3);
      pulse(srcTab[k]);
      meas(k > 3 ? POR + 32 : 32, k == 3 ? 16'hFEFE : 16'hFFFE);
      xfer(0, 8'h04, 0, causeTab[k], 2'b00, 32'hFFFF_FFFF);
      xfer(0, 8'h00, 0, 32'h0000_0000, 2'b00, 32'hFFFF_FFFF);
    end
    $display("end of reset source test");
    pulse(10'h008);
    cyc(3);
    chk(rstPinOe, 1'b0);
    xfer(1, 8'h00, 32'h0000_0000, 0, 2'b00, 0);
    pulse(10'h080);
    meas(32, 16'hFFFE);
    xfer(1, 8'h04, 32'h0000_0000, 0, 2'b00, 0);
    xfer(0, 8'h04, 0, 32'h0000_0010, 2'b00, 32'hFFFF_FFFF);
    @(posedge clk);
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    a = 0;
    while (!resetVecFetch && a < 400) begin cyc(1); a++; end
    chk(a >= 110 && a <= 122, 1'b1);
    cyc(4);
    xfer(0, 8'h04, 0, 32'h0000_0040, 2'b00, 32'hFFFF_FFFF);
    $display("end of pin and stop reset test");
    for (int k = 0; k < 2; k++) begin
      xfer(1, 8'h00, k ? 32'h0000_0006 : 32'h0000_0002, 0, 2'b00, 0);
      pulse(10'h080);
      xfer(0, 8'h08, 0, 32'h0000_6000, 2'b00, 32'h0000_7FFF);
      pulse(10'h200);
      a = 0;
      while (!cpuClkEn && a < 300) begin cyc(1); a++; end
      b = k ? 32 : POR;
      chk(a >= b && a <= b + 8, 1'b1);
    end
    cnt16(a, b, c);
    chk(a, 4);
    chk(c, 16);
    a = watchdogPrescale;
    cyc(1);
    chk((watchdogPrescale - a) & 32'h0000_0FFF, 1);
    pulse(10'h100);
    cyc(2);
    cnt16(a, b, c);
    chk(a, 0);
    chk(b, 4);
    pulse(10'h200);
    xfer(1, 8'h00, 32'h0000_000B, 0, 2'b00, 0);
    cnt16(a, b, c);
    chk(a, 2);
    chk(b, 2);
    chk(c, 8);
    chk(oscOnInStop, 1'b1);
    $display("end of stop and wait test");
    @(posedge clk);
    monitorMode <= 1'b1;
    testHighVoltRst <= 1'b1;
    cyc(4);
    chk(watchdogDisable, 1'b1);
    @(posedge clk);
    testHighVoltRst <= 1'b0;
    testHighVoltIrq <= 1'b1;
    cyc(4);
    chk(watchdogDisable, 1'b1);
    @(posedge clk);
    monitorMode <= 1'b0;
    cyc(4);
    chk(watchdogDisable, 1'b0);
    @(posedge clk);
    breakActive <= 1'b1;
    cyc(4);
    chk(watchdogDisable, 1'b0);
    @(posedge clk);
    testHighVoltRst <= 1'b1;
    cyc(4);
    chk(watchdogDisable, 1'b1);
    pulse(10'h001);
    cyc(3);
    chk(rstPinOe, 1'b0);
    $display("end of watchdog disable test");
    close_out;
  end
endmodule
`default_nettype wire
